/* File: hms_params.svh */
/*
  constants of the hall measurement sequencing block: register addresses,
  field positions, reset values and cycle counts.
  assumes it is included by bare name from the design files only.
*/
// Functional notes
// - length 512 yields 15-bit signed results
// - trims reset to 32, 5 and 8
// - start word holds gain, pixel, axis, length, start
// - gain 128 is 010b, 64 is 001b
// - single length is twice field, plus 512 when the long bit is set
// - temperature run keeps next hall sensor powered
// - sequencer runs continuously, spi cannot slow it
// - result mode register routes flags into upper bits
// - ready toggles per sequencer result, slot 0 readable
// - phase lasts six plus settle plus length
// - hall uses four phases, two with the fast bit set; temperature two
// - converter code symmetric, magnitude at most 7.5
// - status: ready 15, range 13, slot 10-9, fc 8-4
`ifndef HMS_PARAMS_SVH
`define HMS_PARAMS_SVH

`define HMS_A_START     9'h001
`define HMS_A_TIMING    9'h002
`define HMS_A_REGULATOR 9'h003
`define HMS_A_OFFSET    9'h004
`define HMS_A_RDMODE    9'h005
`define HMS_A_POWER     9'h006
`define HMS_A_SEQ_RUN   9'h02f
`define HMS_A_SLOT0     9'h030
`define HMS_A_TRIM      9'h040
`define HMS_A_RESULT    9'h100
`define HMS_A_STATUS    9'h102
`define HMS_A_SLOT0_RES 9'h130

`define HMS_TRIM_RST    16'h4058
`define HMS_REF_TRIM_DEF  6'h20
`define HMS_BIAS_TRIM_DEF 4'h5
`define HMS_REG_TRIM_DEF  4'h8

`define HMS_CMD_WRITE   15
`define HMS_GAIN_HI     15
`define HMS_GAIN_LO     13
`define HMS_TEMP_BIT    12
`define HMS_PIX_HI      11
`define HMS_PIX_LO      10
`define HMS_AXIS_HI     9
`define HMS_AXIS_LO     8
`define HMS_LEN_HI      7
`define HMS_LEN_LO      1
`define HMS_GO_BIT      0
`define HMS_AMP_HI      15
`define HMS_AMP_LO      13
`define HMS_FAST_BIT    12
`define HMS_LONG_BIT    9
`define HMS_WAIT_HI     7
`define HMS_WAIT_LO     0
`define HMS_RNG_BIT     5
`define HMS_SN_BIT      4
`define HMS_PAR_BIT     3
`define HMS_RM_BIT      1
`define HMS_REF_HI      14
`define HMS_REF_LO      9
`define HMS_BIAS_HI     7
`define HMS_BIAS_LO     4
`define HMS_REG_HI      3
`define HMS_REG_LO      0

`define HMS_GAIN_128    3'h2
`define HMS_GAIN_64     3'h1
`define HMS_AXIS_X      2'h0
`define HMS_AXIS_Z      2'h2
`define HMS_SLOT0_NUM   2'h0

`define HMS_PHASE_OVH   10'h006
`define HMS_LONG_BASE   10'h200
`define HMS_MIN_LEN     10'h002
`define HMS_HALL_PHASES 3'h4
`define HMS_TEMP_PHASES 3'h2
`define HMS_ADC_MID     6'h0f
`define HMS_RES_LIMIT   17'h03c00

`endif

/* File: hms_pkg.sv */
/*
  types of the hall measurement sequencing block.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none

package hms_pkg;

  typedef enum logic [1:0] {HMS_IDLE, HMS_SETTLE, HMS_INTEG} hms_state_e;

endpackage : hms_pkg

`default_nettype wire

/* File: hms_top.sv */
/*
  hall measurement sequencing: spi command slave on the spi clock, register
  set and measurement engine on sys_clk, which stands in for the sensor's
  system clock.
  assumes spi mode 0, 16-bit words msb first, spi_cs_n high during srst,
  and adc_code produced on sys_clk.
*/
`include "hms_params.svh"
`default_nettype none

module hms_top
  import hms_pkg::*;
#(
  parameter int ACC_W = 18
)
(
  input  wire  logic        sys_clk,
  input  wire  logic        srst,
  input  wire  logic        spi_sck,
  input  wire  logic        spi_cs_n,
  input  wire  logic        spi_mosi,
  output logic              spi_miso_o,
  output logic              spi_miso_oe,
  input  wire  logic [3:0]  adc_code,
  output logic              meas_ready,
  output logic              hall_power_en,
  output logic              temp_active,
  output logic              integrating,
  output logic [1:0]        hall_pixel,
  output logic [1:0]        hall_axis,
  output logic [2:0]        hall_gain,
  output logic [2:0]        phase_idx,
  output logic [5:0]        reference_trim,
  output logic [3:0]        bias_current_trim,
  output logic [3:0]        regulator_trim,
  output logic [2:0]        amplifier_compensation,
  output logic [15:0]       regulator_ctrl,
  output logic [15:0]       offset_center_ctrl,
  output logic [15:0]       power_ctrl
);

  // the result taps bits 17:1 of the accumulator
  if (ACC_W < 18)
  begin : g_acc_w_check
    $error("hms_top: ACC_W must be at least 18");
  end

  // ---------------- spi clock domain ----------------
  logic [3:0]  bit_cnt_r;
  logic [14:0] shift_r;
  logic [15:0] word_r;
  logic        word_is_data_r;
  logic        expect_data_r;
  logic        word_tgl_r;
  logic [15:0] answer_r;

  // a frame end resets the bit position, the spi clock may stop anytime
  always_ff @(posedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      bit_cnt_r <= 4'h0;
    else
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  always_ff @(posedge spi_sck)
  begin
    shift_r <= {shift_r[13:0], spi_mosi};
    if (bit_cnt_r == 4'hf)
    begin
      word_r         <= {shift_r, spi_mosi};
      word_is_data_r <= expect_data_r;
    end
  end

  // a write pair must sit inside one frame
  always_ff @(posedge spi_sck or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      expect_data_r <= 1'b0;
    else if (bit_cnt_r == 4'hf)
      expect_data_r <= !expect_data_r && shift_r[14];
  end

  always_ff @(posedge spi_sck or posedge srst)
  begin
    if (srst)
      word_tgl_r <= 1'b0;
    else if (bit_cnt_r == 4'hf)
      word_tgl_r <= !word_tgl_r;
  end

  // answer_r is held stable in sys_clk domain long before it is shifted
  assign spi_miso_o  = answer_r[~bit_cnt_r];
  assign spi_miso_oe = !spi_cs_n;

  // ---------------- sys_clk domain ----------------
  logic       tgl_s1_r;
  logic       tgl_s2_r;
  logic       tgl_s3_r;
  logic       word_ev;
  logic [8:0] cmd_addr_r;
  logic       wr_ev;
  logic       rd_ev;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end
    else
    begin
      tgl_s1_r <= word_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign word_ev = tgl_s2_r ^ tgl_s3_r;
  assign wr_ev   = word_ev && word_is_data_r;
  assign rd_ev   = word_ev && !word_is_data_r && !word_r[`HMS_CMD_WRITE];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cmd_addr_r <= 9'h000;
    else if (word_ev && !word_is_data_r && word_r[`HMS_CMD_WRITE])
      cmd_addr_r <= word_r[8:0];
  end

  // configuration registers
  logic [15:0] timing_r;
  logic [15:0] rdmode_r;
  logic [15:0] seq_run_r;
  logic [15:0] slot0_r;
  logic [15:0] trim_r;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      timing_r           <= 16'h0000;
      regulator_ctrl     <= 16'h0000;
      offset_center_ctrl <= 16'h0000;
      rdmode_r           <= 16'h0000;
      power_ctrl         <= 16'h0000;
      seq_run_r          <= 16'h0000;
      slot0_r            <= 16'h0000;
      trim_r             <= `HMS_TRIM_RST;
    end
    else if (wr_ev)
    begin
      unique case (cmd_addr_r)
        `HMS_A_TIMING:    timing_r           <= word_r;
        `HMS_A_REGULATOR: regulator_ctrl     <= word_r;
        `HMS_A_OFFSET:    offset_center_ctrl <= word_r;
        `HMS_A_RDMODE:    rdmode_r           <= word_r;
        `HMS_A_POWER:     power_ctrl         <= word_r;
        `HMS_A_SEQ_RUN:   seq_run_r          <= word_r;
        `HMS_A_SLOT0:     slot0_r            <= word_r;
        `HMS_A_TRIM:      trim_r             <= word_r;
        default:          ;
      endcase
    end
  end

  assign reference_trim         = trim_r[`HMS_REF_HI:`HMS_REF_LO];
  assign bias_current_trim      = trim_r[`HMS_BIAS_HI:`HMS_BIAS_LO];
  assign regulator_trim         = trim_r[`HMS_REG_HI:`HMS_REG_LO];
  assign amplifier_compensation = timing_r[`HMS_AMP_HI:`HMS_AMP_LO];

  // ---------------- measurement engine ----------------
  hms_state_e        st_r;
  logic [9:0]        cnt_r;
  logic [2:0]        phase_r;
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_sum;
  logic signed [5:0] sample;
  logic        act_temp_r;
  logic [1:0]  act_pix_r;
  logic [1:0]  act_axis_r;
  logic [2:0]  act_gain_r;
  logic [9:0]  act_len_r;
  logic [9:0]  act_wait_r;
  logic [2:0]  act_nph_r;
  logic        act_seq_r;
  logic        seq_mode;
  logic        single_go;
  logic        launch;
  logic        done;
  logic        phase_end;
  logic        load;
  logic [15:0] src;
  logic [9:0]  src_len;
  logic [9:0]  new_wait;
  logic [9:0]  settle_new;

  assign seq_mode  = seq_run_r[0] && slot0_r[`HMS_GO_BIT];
  // starts during a running measurement are ignored
  assign single_go = wr_ev && cmd_addr_r == `HMS_A_START
                     && word_r[`HMS_GO_BIT];
  assign launch    = st_r == HMS_IDLE && (seq_mode || single_go);
  assign phase_end = st_r == HMS_INTEG && cnt_r == 10'h000;
  assign done      = phase_end && phase_r == act_nph_r - 3'h1;
  // sequencer restarts in the finishing cycle, so no idle gap
  assign load      = launch || (done && seq_mode);
  assign src       = seq_mode ? slot0_r : word_r;

  // symmetric code: 2*code-15 in half digits, range -7.5..+7.5
  assign sample  = $signed({1'b0, adc_code, 1'b0}) - $signed(`HMS_ADC_MID);
  assign acc_sum = acc_r + ACC_W'(sample);

  always_comb
  begin
    src_len = {1'b0, src[`HMS_LEN_HI:`HMS_LEN_LO], 2'b00} >> 1;
    if (!seq_mode && timing_r[`HMS_LONG_BIT])
      src_len = src_len + `HMS_LONG_BASE;
    if (src_len == 10'h000)
      src_len = `HMS_MIN_LEN;
  end

  assign new_wait   = {2'b00, timing_r[`HMS_WAIT_HI:`HMS_WAIT_LO]};
  assign settle_new = `HMS_PHASE_OVH + new_wait - 10'h001;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      act_temp_r <= 1'b0;
      act_pix_r  <= 2'h0;
      act_axis_r <= 2'h0;
      act_gain_r <= 3'h0;
      act_len_r  <= `HMS_MIN_LEN;
      act_wait_r <= 10'h000;
      act_nph_r  <= `HMS_HALL_PHASES;
      act_seq_r  <= 1'b0;
    end
    else if (load)
    begin
      act_temp_r <= src[`HMS_TEMP_BIT];
      act_pix_r  <= src[`HMS_PIX_HI:`HMS_PIX_LO];
      act_axis_r <= src[`HMS_AXIS_HI:`HMS_AXIS_LO];
      act_gain_r <= src[`HMS_GAIN_HI:`HMS_GAIN_LO];
      act_len_r  <= src_len;
      act_wait_r <= new_wait;
      act_seq_r  <= seq_mode;
      if (src[`HMS_TEMP_BIT] || timing_r[`HMS_FAST_BIT])
        act_nph_r <= `HMS_TEMP_PHASES;
      else
        act_nph_r <= `HMS_HALL_PHASES;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_r    <= HMS_IDLE;
      cnt_r   <= 10'h000;
      phase_r <= 3'h0;
      acc_r   <= '0;
    end
    else if (load)
    begin
      st_r    <= HMS_SETTLE;
      cnt_r   <= settle_new;
      phase_r <= 3'h0;
      acc_r   <= '0;
    end
    else
    begin
      unique case (st_r)
        HMS_IDLE: ;
        HMS_SETTLE:
        begin
          if (cnt_r == 10'h000)
          begin
            st_r  <= HMS_INTEG;
            cnt_r <= act_len_r - 10'h001;
          end
          else
            cnt_r <= cnt_r - 10'h001;
        end
        HMS_INTEG:
        begin
          acc_r <= acc_sum;
          if (done)
            st_r <= HMS_IDLE;
          else if (phase_end)
          begin
            st_r    <= HMS_SETTLE;
            phase_r <= phase_r + 3'h1;
            cnt_r   <= `HMS_PHASE_OVH + act_wait_r - 10'h001;
          end
          else
            cnt_r <= cnt_r - 10'h001;
        end
      endcase
    end
  end

  // temperature runs keep the next hall sensor biased at its own gain
  assign hall_power_en = st_r != HMS_IDLE;
  assign temp_active   = hall_power_en && act_temp_r;
  assign integrating   = st_r == HMS_INTEG;
  assign hall_pixel    = act_pix_r;
  assign hall_axis     = act_axis_r;
  assign hall_gain     = act_gain_r;
  assign phase_idx     = phase_r;

  // ---------------- results and status ----------------
  logic [16:0] res_r;
  logic        rng_r;
  logic [4:0]  fc_r;
  logic [16:0] slot0_res_r;
  logic        slot0_rng_r;
  logic [16:0] res_nxt;
  logic [15:0] status_w;
  logic [15:0] rd_data;

  assign res_nxt = acc_sum[17:1];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      res_r       <= 17'h00000;
      rng_r       <= 1'b0;
      fc_r        <= 5'h00;
      slot0_res_r <= 17'h00000;
      slot0_rng_r <= 1'b0;
    end
    else if (done)
    begin
      res_r <= res_nxt;
      rng_r <= res_nxt[16] != res_nxt[15];
      fc_r  <= {act_temp_r, act_pix_r, act_axis_r};
      if (act_seq_r)
      begin
        slot0_res_r <= res_nxt;
        slot0_rng_r <= res_nxt[16] != res_nxt[15];
      end
    end
  end

  // ready: level in single mode, toggles per sequencer result
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      meas_ready <= 1'b0;
    else if (done)
      meas_ready <= act_seq_r ? !meas_ready : 1'b1;
    else if (launch && !seq_mode)
      meas_ready <= 1'b0;
  end

  assign status_w = {meas_ready, 1'b0, rng_r, 2'b00, `HMS_SLOT0_NUM,
                     fc_r, 3'b000, res_r[16]};

  function automatic logic [15:0] pack_result(
    input logic [16:0] v,
    input logic        rg,
    input logic [15:0] m
  );
    logic [3:0] top;
    top = m[`HMS_RM_BIT] ? v[15:12] : v[16:13];
    if (m[`HMS_PAR_BIT])
      top = {^v, top[3:1]};
    if (m[`HMS_SN_BIT])
      top = {`HMS_SLOT0_NUM, top[3:2]};
    if (m[`HMS_RNG_BIT])
      top = {rg, top[3:1]};
    pack_result = {top, m[`HMS_RM_BIT] ? v[11:0] : v[12:1]};
  endfunction : pack_result

  always_comb
  begin
    unique case (word_r[8:0])
      `HMS_A_TIMING:    rd_data = timing_r;
      `HMS_A_REGULATOR: rd_data = regulator_ctrl;
      `HMS_A_OFFSET:    rd_data = offset_center_ctrl;
      `HMS_A_RDMODE:    rd_data = rdmode_r;
      `HMS_A_POWER:     rd_data = power_ctrl;
      `HMS_A_SEQ_RUN:   rd_data = seq_run_r;
      `HMS_A_SLOT0:     rd_data = slot0_r;
      `HMS_A_TRIM:      rd_data = trim_r;
      `HMS_A_RESULT:    rd_data = pack_result(res_r, rng_r, rdmode_r);
      `HMS_A_STATUS:    rd_data = status_w;
      `HMS_A_SLOT0_RES: rd_data = pack_result(slot0_res_r, slot0_rng_r,
                                              rdmode_r);
      default:          rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      answer_r <= 16'h0000;
    else if (rd_ev)
      answer_r <= rd_data;
  end

  // ---------------- checks ----------------
  logic [10:0] ph_cyc_r;

  always_ff @(posedge sys_clk)
  begin
    if (srst || load || phase_end || st_r == HMS_IDLE)
      ph_cyc_r <= 11'h000;
    else
      ph_cyc_r <= ph_cyc_r + 11'h001;
  end

  property p_trim_default;
    @(posedge sys_clk) $fell(srst) |-> reference_trim == `HMS_REF_TRIM_DEF
      && bias_current_trim == `HMS_BIAS_TRIM_DEF
      && regulator_trim == `HMS_REG_TRIM_DEF;
  endproperty
  a_trim_default: assert property (p_trim_default)
    else $error("trims not at defaults after reset");

  property p_len_512;
    @(posedge sys_clk) disable iff (srst)
      (launch && !seq_mode && timing_r[`HMS_LONG_BIT]
       && word_r[`HMS_LEN_HI:`HMS_LEN_LO] == 7'h00)
      |=> act_len_r == `HMS_LONG_BASE;
  endproperty
  a_len_512: assert property (p_len_512)
    else $error("length field zero did not give 512");

  property p_phase_time;
    @(posedge sys_clk) disable iff (srst)
      phase_end |-> 11'(ph_cyc_r) == 11'(`HMS_PHASE_OVH + act_wait_r
                                         + act_len_r - 10'h001);
  endproperty
  a_phase_time: assert property (p_phase_time)
    else $error("phase length not six plus wait plus length");

  property p_phase_count;
    @(posedge sys_clk) disable iff (srst)
      done |-> (act_temp_r ? phase_r == 3'h1
                           : (phase_r == 3'h3 || timing_r[`HMS_FAST_BIT]));
  endproperty
  a_phase_count: assert property (p_phase_count)
    else $error("wrong number of phases");

  property p_res_range;
    @(posedge sys_clk) disable iff (srst)
      (done && act_len_r == `HMS_LONG_BASE && act_nph_r == `HMS_HALL_PHASES)
      |=> ($signed(res_r) <= $signed(`HMS_RES_LIMIT)
           && $signed(res_r) >= -$signed(`HMS_RES_LIMIT));
  endproperty
  a_res_range: assert property (p_res_range)
    else $error("result beyond 15360 at length 512");

  property p_seq_continuous;
    @(posedge sys_clk) disable iff (srst)
      (done && seq_mode) |=> st_r == HMS_SETTLE ##1 st_r == HMS_SETTLE;
  endproperty
  a_seq_continuous: assert property (p_seq_continuous)
    else $error("sequencer did not restart at once");

  property p_start_decode;
    @(posedge sys_clk) disable iff (srst)
      (launch && !seq_mode) |=> act_gain_r == $past(word_r[15:13])
        && act_axis_r == $past(word_r[9:8]) && hall_power_en;
  endproperty
  a_start_decode: assert property (p_start_decode)
    else $error("start word fields not applied");

  property p_temp_power;
    @(posedge sys_clk) disable iff (srst)
      (launch && !seq_mode && word_r[`HMS_TEMP_BIT])
      |=> temp_active && hall_power_en
        && hall_gain == $past(word_r[`HMS_GAIN_HI:`HMS_GAIN_LO])
        && hall_pixel == $past(word_r[`HMS_PIX_HI:`HMS_PIX_LO]);
  endproperty
  a_temp_power: assert property (p_temp_power)
    else $error("hall sensor unpowered during temperature run");

  property p_status_map;
    @(posedge sys_clk) disable iff (srst)
      (done && !act_seq_r) |=> status_w[15] && status_w[12:11] == 2'b00
        && status_w[10:9] == `HMS_SLOT0_NUM && status_w[0] == res_r[16]
        && status_w[8:4] == $past({act_temp_r, act_pix_r, act_axis_r});
  endproperty
  a_status_map: assert property (p_status_map)
    else $error("status word layout wrong");

  property p_write_pair;
    @(posedge sys_clk) disable iff (srst)
      (wr_ev && cmd_addr_r == `HMS_A_TRIM) |=> trim_r == $past(word_r);
  endproperty
  a_write_pair: assert property (p_write_pair)
    else $error("write data not stored");

  property p_flag_route;
    @(posedge sys_clk) disable iff (srst)
      (rd_ev && word_r[8:0] == `HMS_A_RESULT && rdmode_r[`HMS_RNG_BIT])
      |=> answer_r[15] == $past(rng_r);
  endproperty
  a_flag_route: assert property (p_flag_route)
    else $error("range flag not in result bit 15");

endmodule : hms_top

`default_nettype wire

/* File: hms_host.sv */
/*
  spi host model: mode 0 frames of 16-bit words, msb first, own link clock.
  assumes the slave samples mosi on rising spi_sck and answers on miso.
*/
`default_nettype none

module hms_host
(
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic link_clk = 1'b0;
  logic run      = 1'b0;

  always #32 link_clk = ~link_clk;
  // sck only pulses inside words, so the slave never sees a free clock
  assign spi_sck = run & link_clk;

  initial
  begin
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge link_clk);
      spi_mosi = tx[i];
      run      = 1'b1;
      @(posedge link_clk);
      rx[i] = spi_miso_o; // answer of the previous read
    end
    @(negedge link_clk);
    run      = 1'b0;
    spi_mosi = ~spi_mosi;
    // idle link periods give the slave time to hand the word to sys_clk
    repeat (2) @(negedge link_clk);
  endtask : word

  // a write is a command with the top bit set, then its data
  task automatic frame(input logic [15:0] w0, w1, w2, input int n,
                       output logic [15:0] r1, r2);
    logic [15:0] r0;
    r1 = 16'h0000;
    r2 = 16'h0000;
    @(negedge link_clk);
    spi_cs_n = 1'b0;
    word(w0, r0);
    if (n > 1)
      word(w1, r1);
    if (n > 2)
      word(w2, r2);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask : frame

endmodule : hms_host

`default_nettype wire

/* File: hms_tb.sv */
/*
  self-checking bench of hms_top with the spi host model on the link and
  constant converter codes on sys_clk.
  assumes hms_host and the design files are compiled first.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk  = 1'b0;
  logic        srst     = 1'b1;
  logic [3:0]  adc_code = 4'h0;
  logic        spi_sck, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe;
  logic        meas_ready, hall_power_en, temp_active, integrating;
  logic [1:0]  hall_pixel, hall_axis;
  logic [2:0]  hall_gain, phase_idx, amplifier_compensation;
  logic [5:0]  reference_trim;
  logic [3:0]  bias_current_trim, regulator_trim;
  logic [15:0] regulator_ctrl, offset_center_ctrl, power_ctrl;
  logic [15:0] st, res, r1, r2;
  logic [13:0] trims;
  logic        saw_temp = 1'b0;
  int          busy_cyc = 0;
  int          integ_cyc = 0;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  assign trims = {reference_trim, bias_current_trim, regulator_trim};

  always @(posedge sys_clk)
  begin
    if (hall_power_en === 1'b1)
      busy_cyc <= busy_cyc + 1;
    if (integrating === 1'b1)
      integ_cyc <= integ_cyc + 1;
    if (temp_active === 1'b1)
      saw_temp <= 1'b1;
  end

  hms_top u_dut
  (
    .sys_clk(sys_clk), .srst(srst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
    .spi_miso_oe(spi_miso_oe), .adc_code(adc_code),
    .meas_ready(meas_ready), .hall_power_en(hall_power_en),
    .temp_active(temp_active), .integrating(integrating),
    .hall_pixel(hall_pixel), .hall_axis(hall_axis), .hall_gain(hall_gain),
    .phase_idx(phase_idx), .reference_trim(reference_trim),
    .bias_current_trim(bias_current_trim), .regulator_trim(regulator_trim),
    .amplifier_compensation(amplifier_compensation),
    .regulator_ctrl(regulator_ctrl), .offset_center_ctrl(offset_center_ctrl),
    .power_ctrl(power_ctrl)
  );

  hms_host u_host
  (
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o)
  );

  task automatic summarize;
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo(input int k, input int lim);
    if (k >= lim)
    begin
      n_fail++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, k, lim);
      summarize();
    end
  endtask : tmo

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    u_host.frame({7'h40, a}, d, 16'h0000, 2, r1, r2);
  endtask : wr

  // start, wait for the engine, then read status and result in one frame
  task automatic measure(input logic [15:0] sw, input int n, input int m);
    int k;
    tick();
    busy_cyc  = 0;
    integ_cyc = 0;
    saw_temp  = 1'b0;
    wr(9'h001, sw);
    chk(meas_ready, 1'b0);
    k = 0;
    while (hall_power_en !== 1'b0 && k < 5000)
    begin
      tick();
      k++;
    end
    tmo(k, 5000);
    tick();
    chk(meas_ready, 1'b1);
    chk(busy_cyc >= n && busy_cyc <= n + 1, 1'b1);
    chk(integ_cyc == m, 1'b1);
    u_host.frame(16'h0102, 16'h0100, 16'h0000, 3, st, res);
  endtask : measure

  task automatic gap(output int cyc);
    logic p;
    p = meas_ready;
    cyc = 0;
    do
    begin
      tick();
      cyc++;
    end
    while (meas_ready === p && cyc < 400);
  endtask : gap

  task automatic t_reset;
    chk(trims, 14'h2058);
    chk({meas_ready, hall_power_en, spi_miso_oe}, 3'h0);
  endtask : t_reset

  task automatic t_config;
    wr(9'h040, 16'h2a3c);
    chk(trims, 14'h153c);
    wr(9'h040, 16'h4058);
    chk(trims, 14'h2058);
    wr(9'h002, 16'he250);
    wr(9'h003, 16'ha000);
    wr(9'h004, 16'h0aa9);
    wr(9'h005, 16'h0002);
    wr(9'h006, 16'h077f);
    chk(amplifier_compensation, 3'h7);
    chk(regulator_ctrl, 16'ha000);
    chk(offset_center_ctrl, 16'h0aa9);
    // a command cut off by frame end must not eat the next frame's word
    u_host.frame(16'h8006, 16'h0000, 16'h0000, 1, r1, r2);
    u_host.frame(16'h01ff, 16'h0000, 16'h0000, 2, r1, r2);
    chk(r1, 16'h0000);
    chk(power_ctrl, 16'h077f);
  endtask : t_config

  task automatic t_hall;
    @(posedge sys_clk);
    adc_code <= 4'hf;
    measure(16'h4001, 2392, 2048);
    chk(st, 16'h8000);
    chk(res, 16'h3c00);
    chk({hall_gain, hall_pixel, hall_axis}, 7'h20);
    chk(phase_idx, 3'h3);
    @(posedge sys_clk);
    adc_code <= 4'h0;
    measure(16'h2601, 2392, 2048);
    chk(st, 16'h8061);
    chk(res, 16'hc400);
    chk({hall_gain, hall_pixel, hall_axis}, 7'h16);
  endtask : t_hall

  task automatic t_temp;
    @(posedge sys_clk);
    adc_code <= 4'hf;
    measure(16'h5041, 1324, 1152);
    chk(saw_temp, 1'b1);
    chk({hall_gain, hall_pixel, hall_axis}, 7'h20);
    chk(phase_idx, 3'h1);
    chk(st, 16'h8100);
    chk(res, 16'h21c0);
  endtask : t_temp

  task automatic t_seq;
    int c0, c1, c2;
    @(posedge sys_clk);
    adc_code <= 4'h0;
    wr(9'h002, 16'hf00a);
    wr(9'h005, 16'h003a);
    wr(9'h030, 16'h6223);
    wr(9'h02f, 16'h0001);
    // read traffic runs across the timed toggles on purpose
    fork
      u_host.frame(16'h0130, 16'h0100, 16'h0000, 3, r1, r2);
      begin
        gap(c0);
        gap(c1);
        gap(c2);
      end
    join
    tmo(c0, 400);
    chk(c1, 17'h00064);
    chk(c2, 17'h00064);
    chk(r1, 16'h1e02);
    chk(r2, 16'h1e02);
  endtask : t_seq

  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) tick();
    t_reset();
    t_config();
    t_hall();
    t_temp();
    t_seq();
    summarize();
  end

endmodule : testbench

`default_nettype wire
